/* tcbdma_pkg.sv */
package tcbdma_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_INDEX_STATUS = 8'h3f;
  localparam logic [7:0] ADDR_MODE_ONE = 8'h40;
  localparam logic [7:0] ADDR_MODE_TWO = 8'h41;
  localparam logic [7:0] ADDR_SOURCE_LOW = 8'h42;
  localparam logic [7:0] ADDR_SOURCE_HIGH = 8'h43;
  localparam logic [7:0] ADDR_DESTINATION_LOW = 8'h44;
  localparam logic [7:0] ADDR_DESTINATION_HIGH = 8'h45;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h46;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h47;

  ////////////////////////////////////////////////////////////////////////////////
  // Index and status register bit positions
  localparam int IS_INDEX_BIT = 7;
  localparam int IS_RELOAD_DISABLE_BIT = 6;
  localparam int IS_LATCH_CLEAR_BIT = 4;
  localparam int IS_TRIGGER_BIT = 2;
  localparam int IS_FLAG_BIT = 0;

  // Mode register two bit positions
  localparam int M2_RELOAD_NOW_BIT = 4;
  localparam int M2_SELECT_WIDTH = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths, field indices and reset values
  localparam int NUM_CHANNELS = 2;
  localparam int NUM_FIELDS = 3;
  localparam int FIELD_SOURCE = 0;
  localparam int FIELD_DESTINATION = 1;
  localparam int FIELD_COUNT = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [3:0] SELECT_NONE = 4'h0;

  // Mode register one, bit 7 down to bit 0
  typedef struct packed {
    logic channelEnable;
    logic deferredWriteLoad;
    logic stopAfterUnderflow;
    logic burstMode;
    logic destinationStepEnable;
    logic destinationStepDirection;
    logic sourceStepEnable;
    logic sourceStepDirection;
  } tcbdma_mode1_t;

  // Working pointers of one channel
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] destination;
    logic [15:0] source;
  } tcbdma_ptrs_t;

  // Memory bus driven toward the shared memory
  typedef struct packed {
    logic [15:0] addr;
    logic read;
    logic write;
    logic [7:0] wdata;
  } tcbdma_mem_t;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_GAP = 2'b11
  } tcbdma_state_t;

  // Address step: hold, plus one, or minus one
  function automatic logic [15:0] tcbdma_step(input logic [15:0] a, input logic en,
                                              input logic dec);
    logic [15:0] r;
    r = a;
    if (en && dec) begin
      r = a - STEP_ONE;
    end else if (en) begin
      r = a + STEP_ONE;
    end
    return r;
  endfunction

endpackage

/* tcbdma_req_latch.sv */
`timescale 1ns/1ns
`default_nettype none
module tcbdma_req_latch
  import tcbdma_pkg::*;
#(
  parameter int SEL_WIDTH = M2_SELECT_WIDTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [(2**SEL_WIDTH)-1:0] sources,
  input wire logic [SEL_WIDTH-1:0] select,
  input wire logic softwareTrigger,
  input wire logic latchClear,
  input wire logic grant,
  output logic pending
);

  // Previous sample of every source, so a select change cannot fake a new edge
  logic [(2**SEL_WIDTH)-1:0] prevSources;
  // Rising edges of all sources
  wire logic [(2**SEL_WIDTH)-1:0] rise = sources & ~prevSources;
  // Selected hardware request; code zero means software only
  wire logic hwHit = (select != SEL_WIDTH'(SELECT_NONE)) && rise[select];
  wire logic setReq = hwHit || softwareTrigger;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample latch: set wins over clear, many requests merge into one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prevSources <= '0;
      pending <= 1'b0;
    end else begin
      prevSources <= sources;
      if (setReq) begin
        pending <= 1'b1;
      end else if (grant || latchClear) begin
        pending <= 1'b0;
      end
    end
  end

  chk_trigger_pending: assert property (@(posedge sys_clk) disable iff (sys_rst)
    softwareTrigger |=> pending) else $error("software trigger not latched");

  chk_software_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (select == SEL_WIDTH'(SELECT_NONE) && !softwareTrigger && !pending) |=> !pending)
    else $error("request latched with no source selected");

endmodule // tcbdma_req_latch
`default_nettype wire

/* tcbdma_channel.sv */
`timescale 1ns/1ns
`default_nettype none
module tcbdma_channel
  import tcbdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [NUM_FIELDS-1:0] lowWrite,
  input wire logic [NUM_FIELDS-1:0] highWrite,
  input wire logic [NUM_FIELDS-1:0] highRead,
  input wire logic [7:0] wrData,
  input wire tcbdma_mode1_t mode,
  input wire logic reloadNow,
  input wire logic globalReloadDisable,
  input wire logic step,
  output tcbdma_ptrs_t ptrs,
  output logic [NUM_FIELDS-1:0][7:0] snapLow,
  output logic underflow
);

  // Working registers, reload latches and staged low bytes
  logic [NUM_FIELDS-1:0][15:0] work;
  logic [NUM_FIELDS-1:0][15:0] reloadLatch;
  logic [NUM_FIELDS-1:0][7:0] lowStage;

  // Per field step controls; the count always steps down by one
  wire logic [NUM_FIELDS-1:0] stepEn = {1'b1, mode.destinationStepEnable,
                                        mode.sourceStepEnable};
  wire logic [NUM_FIELDS-1:0] stepDec = {1'b1, mode.destinationStepDirection,
                                         mode.sourceStepDirection};
  // Addresses skip reload when the shared disable is set; the count never does
  wire logic [NUM_FIELDS-1:0] reloadOnUf = {1'b1, ~globalReloadDisable,
                                            ~globalReloadDisable};

  // Underflow is the step taken from a count of zero
  assign underflow = step && (work[FIELD_COUNT] == RESET_WORD);
  assign ptrs = {work[FIELD_COUNT], work[FIELD_DESTINATION], work[FIELD_SOURCE]};
  // Low bytes captured by the last high-byte read
  logic [NUM_FIELDS-1:0][7:0] snapReg;
  assign snapLow = snapReg;

  genvar f;
  generate
    for (f = 0; f < NUM_FIELDS; f++) begin : g_field
      // Next working value, highest priority first
      logic [15:0] nextWork;
      always_comb begin
        nextWork = work[f];
        if (highWrite[f] && !mode.deferredWriteLoad) begin
          nextWork = {wrData, lowStage[f]};
        end else if (reloadNow) begin
          nextWork = reloadLatch[f];
        end else if (underflow && reloadOnUf[f]) begin
          nextWork = reloadLatch[f];
        end else if (step) begin
          nextWork = tcbdma_step(work[f], stepEn[f], stepDec[f]);
        end
      end

      // Byte staging, latch transfer and read snapshot
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          work[f] <= RESET_WORD;
          reloadLatch[f] <= RESET_WORD;
          lowStage[f] <= RESET_BYTE;
          snapReg[f] <= RESET_BYTE;
        end else begin
          work[f] <= nextWork;
          if (lowWrite[f]) begin
            lowStage[f] <= wrData;
          end
          if (highWrite[f]) begin
            reloadLatch[f] <= {wrData, lowStage[f]};
          end
          if (highRead[f]) begin
            snapReg[f] <= work[f][7:0];
          end
        end
      end
    end
  endgenerate

endmodule // tcbdma_channel
`default_nettype wire

/* two_channel_byte_dma.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Channel zero wins over channel one when both wait in idle
// - Each byte takes a read then a write
// - CPU and other channel held during byte
// - Read byte held, written next cycle
// - Two free CPU cycles (gap, idle) between separate transfers
// - Single mode one byte, burst several bytes
// - Sixteen-bit source and destination per channel
// - Count drops by one per byte
// - Up to 65,536 bytes before underflow
// - Mode bits choose increment, decrement or hold
// - Underflow reloads, sets flag, raises interrupt
// - Global bit blocks address reload, both channels
// - Stop-after-underflow clears channel enable
// - Reload-now loads the visible channel's registers from latches
// - Index bit seven picks visible channel
// - High write loads working unless deferred
// - Hardware peripheral and software request sources
// - High read first, low returns snapshot
// - Software trigger bit starts a transfer
// - Zero select means software trigger only
// - Request latch clears, extra requests merge
module two_channel_byte_dma
  import tcbdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [NUM_CHANNELS-1:0][15:0] reqSources,
  output tcbdma_mem_t memBus,
  input wire logic [7:0] memRdData,
  output logic cpuHold,
  output logic [NUM_CHANNELS-1:0] channelIrq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Control and status state

  // Visible channel index
  logic channelSelect;
  // Shared address reload disable
  logic globalReloadDisable;
  // Sticky underflow flags
  logic [NUM_CHANNELS-1:0] underflowFlag;
  // Per channel mode registers
  tcbdma_mode1_t mode1 [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0][M2_SELECT_WIDTH-1:0] hwSelect;
  // Sequencer
  tcbdma_state_t state;
  tcbdma_state_t next_state;
  logic activeCh;
  logic next_activeCh;
  // Underflow seen on the current byte; ends a burst
  logic ufSeen;

  // Channel outputs
  tcbdma_ptrs_t ptrs [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0][NUM_FIELDS-1:0][7:0] snapLow;
  logic [NUM_CHANNELS-1:0] underflow;
  logic [NUM_CHANNELS-1:0] pending;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire logic wrStatus = regWrite && (regAddr == ADDR_INDEX_STATUS);
  wire logic wrMode1 = regWrite && (regAddr == ADDR_MODE_ONE);
  wire logic wrMode2 = regWrite && (regAddr == ADDR_MODE_TWO);
  // Low and high byte strobes of the three pointer fields
  wire logic [NUM_FIELDS-1:0] addrLow = {regAddr == ADDR_COUNT_LOW,
                                         regAddr == ADDR_DESTINATION_LOW,
                                         regAddr == ADDR_SOURCE_LOW};
  wire logic [NUM_FIELDS-1:0] addrHigh = {regAddr == ADDR_COUNT_HIGH,
                                          regAddr == ADDR_DESTINATION_HIGH,
                                          regAddr == ADDR_SOURCE_HIGH};
  // Reload command bit of mode register two
  wire logic reloadCmd = wrMode2 && regWrData[M2_RELOAD_NOW_BIT];
  // Flag bits written with zero are cleared
  wire logic [NUM_CHANNELS-1:0] flagClear =
    {NUM_CHANNELS{wrStatus}} & ~regWrData[IS_FLAG_BIT +: NUM_CHANNELS];
  // Trigger and latch-clear bits act only on the write cycle
  wire logic [NUM_CHANNELS-1:0] swTrigger =
    {NUM_CHANNELS{wrStatus}} & regWrData[IS_TRIGGER_BIT +: NUM_CHANNELS];
  wire logic [NUM_CHANNELS-1:0] latchClear =
    {NUM_CHANNELS{wrStatus}} & regWrData[IS_LATCH_CLEAR_BIT +: NUM_CHANNELS];

  // Serviceable requests
  wire logic [NUM_CHANNELS-1:0] req = pending & {mode1[1].channelEnable,
                                                 mode1[0].channelEnable};
  // Grant only from idle; the gap state keeps the CPU cycle free
  wire logic grantValid = (state == ST_IDLE) && (req != '0);
  wire logic grantCh = !req[0];
  // Step pulse for the active channel, taken on its read cycle
  wire logic stepNow = (state == ST_READ);
  // Burst carries on until underflow or disable
  wire logic burstGo = mode1[activeCh].burstMode && mode1[activeCh].channelEnable && !ufSeen;

  ////////////////////////////////////////////////////////////////////////////////
  // Channels and their request latches

  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      // Only the channel picked by the index sees pointer and mode register strobes
      wire logic picked = (channelSelect == 1'(c));
      wire logic [NUM_FIELDS-1:0] lowWr = addrLow & {NUM_FIELDS{regWrite && picked}};
      wire logic [NUM_FIELDS-1:0] highWr = addrHigh & {NUM_FIELDS{regWrite && picked}};
      wire logic [NUM_FIELDS-1:0] highRd = addrHigh & {NUM_FIELDS{regRead && picked}};

      tcbdma_channel u_channel (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .lowWrite(lowWr),
        .highWrite(highWr),
        .highRead(highRd),
        .wrData(regWrData),
        .mode(mode1[c]),
        .reloadNow(reloadCmd && picked),
        .globalReloadDisable(globalReloadDisable),
        .step(stepNow && (activeCh == 1'(c))),
        .ptrs(ptrs[c]),
        .snapLow(snapLow[c]),
        .underflow(underflow[c])
      );

      tcbdma_req_latch u_req_latch (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sources(reqSources[c]),
        .select(hwSelect[c]),
        .softwareTrigger(swTrigger[c]),
        .latchClear(latchClear[c]),
        .grant(grantValid && (grantCh == 1'(c))),
        .pending(pending[c])
      );

      // Mode registers; hardware stop wins over a software write
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          mode1[c] <= '0;
          hwSelect[c] <= SELECT_NONE;
        end else begin
          if (wrMode1 && picked) begin
            mode1[c] <= regWrData;
          end
          if (wrMode2 && picked) begin
            hwSelect[c] <= regWrData[M2_SELECT_WIDTH-1:0];
          end
          if (underflow[c] && mode1[c].stopAfterUnderflow) begin
            mode1[c].channelEnable <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer: idle, read, write, then a free CPU cycle
  always_comb begin
    next_state = state;
    next_activeCh = activeCh;
    case (state)
      ST_IDLE: begin
        if (grantValid) begin
          next_state = ST_READ;
          next_activeCh = grantCh;
        end
      end
      ST_READ: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        // Burst bytes follow back to back; anything else yields a cycle
        next_state = burstGo ? ST_READ : ST_GAP;
      end
      ST_GAP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registered memory outputs follow the next state
  wire logic [15:0] next_addr = (next_state == ST_WRITE) ?
                                ptrs[activeCh].destination : ptrs[next_activeCh].source;
  wire logic next_busy = (next_state == ST_READ) || (next_state == ST_WRITE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      activeCh <= 1'b0;
      ufSeen <= 1'b0;
      memBus <= '0;
      cpuHold <= 1'b0;
    end else begin
      state <= next_state;
      activeCh <= next_activeCh;
      ufSeen <= stepNow ? underflow[activeCh] : ufSeen;
      memBus.addr <= next_busy ? next_addr : memBus.addr;
      memBus.read <= (next_state == ST_READ);
      memBus.write <= (next_state == ST_WRITE);
      cpuHold <= next_busy;
      // The write data flop is the holding register
      if (state == ST_READ) begin
        memBus.wdata <= memRdData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status register, flags and interrupt pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      channelSelect <= 1'b0;
      globalReloadDisable <= 1'b0;
      underflowFlag <= '0;
      channelIrq <= '0;
    end else begin
      if (wrStatus) begin
        channelSelect <= regWrData[IS_INDEX_BIT];
        globalReloadDisable <= regWrData[IS_RELOAD_DISABLE_BIT];
      end
      // A new underflow beats a clear in the same cycle
      underflowFlag <= (underflowFlag & ~flagClear) | underflow;
      channelIrq <= underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux; the low byte of a pointer comes from the snapshot
  wire logic [7:0] statusRead = {channelSelect, globalReloadDisable, 4'h0, underflowFlag};
  wire tcbdma_ptrs_t selPtrs = ptrs[channelSelect];
  logic [7:0] readMux;
  always_comb begin
    case (regAddr)
      ADDR_INDEX_STATUS: readMux = statusRead;
      ADDR_MODE_ONE: readMux = mode1[channelSelect];
      ADDR_MODE_TWO: readMux = {4'h0, hwSelect[channelSelect]};
      ADDR_SOURCE_LOW: readMux = snapLow[channelSelect][FIELD_SOURCE];
      ADDR_SOURCE_HIGH: readMux = selPtrs.source[15:8];
      ADDR_DESTINATION_LOW: readMux = snapLow[channelSelect][FIELD_DESTINATION];
      ADDR_DESTINATION_HIGH: readMux = selPtrs.destination[15:8];
      ADDR_COUNT_LOW: readMux = snapLow[channelSelect][FIELD_COUNT];
      ADDR_COUNT_HIGH: readMux = selPtrs.count[15:8];
      default: readMux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= RESET_BYTE;
    end else if (regRead) begin
      regRdData <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence seqByte;
    memBus.read ##1 memBus.write;
  endsequence

  chk_read_write: assert property (memBus.read |-> seqByte)
    else $error("read not followed by write");
  chk_cpu_held: assert property ((memBus.read || memBus.write) |-> cpuHold)
    else $error("cpu not held during byte");
  chk_hold_data: assert property (memBus.read |=> memBus.wdata == $past(memRdData))
    else $error("written byte differs from read byte");
  chk_cpu_gap: assert property ((memBus.write ##1 !memBus.read) |-> !cpuHold)
    else $error("no free cpu cycle after transfer");
  chk_fixed_priority: assert property ((state == ST_IDLE && req == 2'b11) |=>
    (activeCh == 1'b0 && memBus.read)) else $error("channel one served first");
  chk_count_step: assert property ((stepNow && activeCh == 1'b0 && !regWrite &&
    ptrs[0].count != RESET_WORD) |=> ptrs[0].count == $past(ptrs[0].count) - STEP_ONE)
    else $error("count did not drop by one");
  chk_underflow_flag: assert property (underflow[0] |=>
    (underflowFlag[0] && channelIrq[0])) else $error("underflow not flagged");
  chk_irq_pulse: assert property (channelIrq[1] |=> !channelIrq[1])
    else $error("interrupt longer than one cycle");
  chk_stop_enable: assert property ((underflow[1] && mode1[1].stopAfterUnderflow) |=>
    !mode1[1].channelEnable) else $error("channel left enabled after underflow");

endmodule // two_channel_byte_dma
`default_nettype wire

/* tcbdma_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Shared memory seen by the transfer engine; reads are combinational
module tcbdma_mem_model
  import tcbdma_pkg::*;
(
  input wire logic sys_clk,
  input wire tcbdma_mem_t memBus,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:65535]; // Whole 64K map
  logic [7:0] lastRd = 8'h00; // Last byte handed out
  // Fill with a known pattern so copied bytes can be recognised
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // Outside a read the data lines show garbage, never a stale byte
  assign memRdData = memBus.read ? mem[memBus.addr] : ~lastRd;
  ////////////////////////////////////////////////////////////////////////////////
  // Writes land at the clock edge
  always @(posedge sys_clk) begin
    if (memBus.read) begin
      lastRd <= mem[memBus.addr];
    end
    if (memBus.write) begin
      mem[memBus.addr] <= memBus.wdata;
    end
  end
endmodule // tcbdma_mem_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tcbdma_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [NUM_CHANNELS-1:0][15:0] reqSources = '0;
  tcbdma_mem_t memBus;
  logic [7:0] memRdData;
  logic cpuHold;
  logic [NUM_CHANNELS-1:0] channelIrq;
  int mismatches = 0;
  int nTests = 0;
  int nReads = 0; // Bytes read by the engine so far
  int nIrq0 = 0;
  int nIrq1 = 0;
  logic [15:0] addrLog [0:31]; // Source address of each byte moved
  logic prevRead = 1'b0;
  logic [7:0] heldByte = 8'h00; // Byte the engine should write next
  logic [7:0] d;
  logic [15:0] v;

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  two_channel_byte_dma dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .reqSources(reqSources), .memBus(memBus), .memRdData(memRdData), .cpuHold(cpuHold),
    .channelIrq(channelIrq));
  tcbdma_mem_model mem (.sys_clk(sys_clk), .memBus(memBus), .memRdData(memRdData));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Pre-edge values are sampled, so the design's own updates never race this
  always @(posedge sys_clk) begin
    if ((memBus.read | memBus.write) === 1'b1) begin
      chk(cpuHold, 1'b1);
    end
    if ((memBus.read | memBus.write) === 1'b0 && !sys_rst) begin
      chk(cpuHold, 1'b0);
    end
    if (prevRead) begin
      chk(memBus.write, 1'b1);
      chk(memBus.wdata, heldByte);
    end
    prevRead <= (memBus.read === 1'b1);
    if (memBus.read === 1'b1) begin
      heldByte <= memRdData;
      addrLog[nReads] <= memBus.addr;
      nReads <= nReads + 1;
    end
    if (channelIrq[0] === 1'b1) nIrq0 <= nIrq0 + 1;
    if (channelIrq[1] === 1'b1) nIrq1 <= nIrq1 + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One strobe per access; a clock edge always passes between strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= dat;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 dat = regRdData;
  endtask

  // Low address given; low byte goes first so the high write commits both
  task automatic wr16(input logic [7:0] a, input logic [15:0] w);
    wr(a, w[7:0]);
    wr(a + 8'h01, w[15:8]);
  endtask

  // High address given; high first captures the low byte
  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    rd(a, w[15:8]);
    rd(a - 8'h01, w[7:0]);
  endtask

  task automatic waitReads(input int target);
    for (int i = 0; i < 200 && nReads < target; i++) @(posedge sys_clk);
    if (nReads < target) begin
      mismatches++;
      $display("timeout waiting for transfers");
      end_sim();
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic pulseReq(input int bitIdx);
    @(posedge sys_clk);
    reqSources[0][bitIdx] <= 1'b1;
    @(posedge sys_clk);
    reqSources[0][bitIdx] <= 1'b0;
  endtask

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped 0x48 included
    for (int a = 8'h3f; a <= 8'h48; a++) begin
      rd(8'(a), d);
      chk(d, 8'h00);
    end
    $display("test reset values done");
    // Channel 0 single mode, incrementing, two bytes then underflow
    wr16(ADDR_SOURCE_LOW, 16'h0010);
    wr16(ADDR_DESTINATION_LOW, 16'h0020);
    wr16(ADDR_COUNT_LOW, 16'h0001);
    wr(ADDR_MODE_ONE, 8'h8A);
    wr(ADDR_INDEX_STATUS, 8'h04);
    waitReads(1);
    chk(16'(nReads), 16'h0001);
    rd16(ADDR_SOURCE_HIGH, v);
    chk(v, 16'h0011);
    rd16(ADDR_DESTINATION_HIGH, v);
    chk(v, 16'h0021);
    rd16(ADDR_COUNT_HIGH, v);
    chk(v, 16'h0000);
    wr(ADDR_INDEX_STATUS, 8'h04);
    waitReads(2);
    chk(mem.mem[16'h0021], pat(16'h0011));
    rd(ADDR_INDEX_STATUS, d);
    chk(d, 8'h01);
    chk(16'(nIrq0), 16'h0001);
    rd16(ADDR_SOURCE_HIGH, v);
    chk(v, 16'h0010);
    rd16(ADDR_COUNT_HIGH, v);
    chk(v, 16'h0001);
    $display("test single mode done");
    // Channel 1 burst, decrementing, stop after underflow
    wr(ADDR_INDEX_STATUS, 8'h80);
    rd16(ADDR_SOURCE_HIGH, v);
    chk(v, 16'h0000);
    wr16(ADDR_SOURCE_LOW, 16'h0105);
    wr16(ADDR_DESTINATION_LOW, 16'h0205);
    wr16(ADDR_COUNT_LOW, 16'h0002);
    wr(ADDR_MODE_ONE, 8'hBF);
    wr(ADDR_INDEX_STATUS, 8'h88);
    waitReads(5);
    for (int i = 3; i <= 5; i++) begin
      chk(mem.mem[16'h0200 + 16'(i)], pat(16'h0100 + 16'(i)));
    end
    chk(16'(nIrq1), 16'h0001);
    rd(ADDR_MODE_ONE, d);
    chk(d, 8'h3F);
    $display("test burst mode done");
    // Both channels at once, address reload blocked
    wr(ADDR_MODE_ONE, 8'hBF);
    wr(ADDR_INDEX_STATUS, 8'h4C);
    waitReads(9);
    chk(addrLog[5], 16'h0010);
    chk(addrLog[6], 16'h0105);
    wr(ADDR_INDEX_STATUS, 8'hC0);
    rd16(ADDR_SOURCE_HIGH, v);
    chk(v, 16'h0102);
    rd16(ADDR_COUNT_HIGH, v);
    chk(v, 16'h0002);
    wr(ADDR_MODE_TWO, 8'h10);
    rd16(ADDR_SOURCE_HIGH, v);
    chk(v, 16'h0105);
    rd(ADDR_MODE_TWO, d);
    chk(d, 8'h00);
    $display("test priority and reload done");
    // Hardware request only counts once a source is selected
    wr(ADDR_INDEX_STATUS, 8'h00);
    pulseReq(3);
    repeat (10) @(posedge sys_clk);
    chk(16'(nReads), 16'h0009);
    wr(ADDR_MODE_TWO, 8'h03);
    pulseReq(3);
    waitReads(10);
    chk(addrLog[9], 16'h0011);
    $display("test hardware request done");
    // Deferred load waits for reload_now; a cleared latch drops its request
    wr(ADDR_MODE_ONE, 8'h40);
    wr16(ADDR_DESTINATION_LOW, 16'h1234);
    rd16(ADDR_DESTINATION_HIGH, v);
    chk(v, 16'h0020);
    wr(ADDR_MODE_TWO, 8'h10);
    rd16(ADDR_DESTINATION_HIGH, v);
    chk(v, 16'h1234);
    wr(ADDR_INDEX_STATUS, 8'h04);
    wr(ADDR_INDEX_STATUS, 8'h10);
    wr(ADDR_MODE_ONE, 8'h80);
    repeat (10) @(posedge sys_clk);
    chk(16'(nReads), 16'h000A);
    wr(ADDR_INDEX_STATUS, 8'h04);
    waitReads(11);
    chk(addrLog[10], 16'h0010);
    chk(mem.mem[16'h1234], pat(16'h0010));
    $display("test deferred load and latch clear done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
